// [shared/stm_pkg.sv]
package stm_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CNT_LO = 8'h00;
  localparam logic [7:0] ADDR_CNT_HI = 8'h04;
  localparam logic [7:0] ADDR_CMPA_LO = 8'h08;
  localparam logic [7:0] ADDR_CMPA_HI = 8'h0C;
  localparam logic [7:0] ADDR_CTRL0 = 8'h10;
  localparam logic [7:0] ADDR_CTRL1 = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // control 0 fields
  localparam int C0_PAUSE = 7;
  localparam int C0_ON = 3;
  localparam int C0_PER_LSB = 0;
  // control 1 fields
  localparam int C1_MODE_LSB = 6;
  localparam int C1_ACT_LSB = 4;
  localparam int C1_OC = 3;
  localparam int C1_INV = 2;
  localparam int C1_SWAP = 1;
  localparam int C1_CLR = 0;
  // status fields
  localparam int ST_AF = 0;
  localparam int ST_PF = 1;
  // reset values and counter top
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [9:0] CNT_RST = 10'h000;
  localparam logic [9:0] CMPA_RST = 10'h000;
  localparam logic [9:0] CNT_MAX = 10'h3FF;
  // modes
  typedef enum logic [1:0] {
    MODE_CMP = 2'b00,
    MODE_CAP = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TMR = 2'b11
  } stm_mode_t;
  // compare-match output actions
  localparam logic [1:0] ACT_NONE = 2'b00;
  localparam logic [1:0] ACT_LOW = 2'b01;
  localparam logic [1:0] ACT_HIGH = 2'b10;
  localparam logic [1:0] ACT_TOGGLE = 2'b11;
endpackage

// [core/stm_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module stm_timer
  import stm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic timer_out,
  output logic timer_out_en
);

  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [9:0] cmpa_reg;
  logic [9:0] cnt_reg;
  logic af_reg;
  logic pf_reg;
  logic on_d_reg;
  logic pin_reg;
  logic pwm_reg;

  logic wr_en;
  logic rd_en;
  logic known;
  logic on_rise;
  logic running;
  stm_mode_t mode;
  logic [1:0] act;
  logic [2:0] per_code;
  logic [9:0] cnt_inc;
  logic match_a;
  logic match_p;
  logic clr_sel;
  logic swap;
  logic wrap_top;
  logic clear_cnt;
  logic set_af;
  logic set_pf;
  logic [10:0] period_len;
  logic [10:0] duty_len;
  logic pwm_active;
  logic af_clr;
  logic pf_clr;
  logic sel_cnt_lo;
  logic sel_cnt_hi;
  logic sel_cmpa_lo;
  logic sel_cmpa_hi;
  logic sel_ctrl0;
  logic sel_ctrl1;
  logic sel_status;
  logic [31:0] rd_value;
  logic [10:0] per_code_len;
  logic on_level;
  logic off_level;
  logic pwm_level;
  logic mode_cmp;
  logic mode_pwm;
  logic pin_drive;

  // address decode
  assign sel_cnt_lo = (paddr == ADDR_CNT_LO);
  assign sel_cnt_hi = (paddr == ADDR_CNT_HI);
  assign sel_cmpa_lo = (paddr == ADDR_CMPA_LO);
  assign sel_cmpa_hi = (paddr == ADDR_CMPA_HI);
  assign sel_ctrl0 = (paddr == ADDR_CTRL0);
  assign sel_ctrl1 = (paddr == ADDR_CTRL1);
  assign sel_status = (paddr == ADDR_STATUS);
  assign known = sel_cnt_lo || sel_cnt_hi || sel_cmpa_lo || sel_cmpa_hi ||
                 sel_ctrl0 || sel_ctrl1 || sel_status;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign mode = stm_mode_t'(ctrl1_reg[C1_MODE_LSB +: 2]);
  assign act = ctrl1_reg[C1_ACT_LSB +: 2];
  assign per_code = ctrl0_reg[C0_PER_LSB +: 3];
  assign clr_sel = ctrl1_reg[C1_CLR];
  assign swap = ctrl1_reg[C1_SWAP];
  assign on_rise = ctrl0_reg[C0_ON] && !on_d_reg;
  assign running = ctrl0_reg[C0_ON] && !ctrl0_reg[C0_PAUSE];
  assign cnt_inc = cnt_reg + 10'h001;

  // matches seen on the count about to be reached (cnt_reg plus one)
  assign match_a = running && (cnt_inc == cmpa_reg);
  assign match_p = running && (per_code != 3'h0) &&
                   (cnt_inc[9:7] == per_code) && (cnt_inc[6:0] == 7'h00);
  assign wrap_top = running && (cnt_reg == CNT_MAX);

  always_comb begin
    clear_cnt = 1'b0;
    set_af = 1'b0;
    set_pf = 1'b0;
    if (mode == MODE_PWM) begin
      set_af = match_a;
      set_pf = match_p || (per_code == 3'h0 && wrap_top);
      clear_cnt = swap ? match_a : match_p;
    end else if (clr_sel) begin
      set_af = match_a;
      clear_cnt = match_a;
    end else begin
      set_af = match_a;
      set_pf = match_p || (per_code == 3'h0 && wrap_top);
      clear_cnt = match_p;
    end
  end

  // period and duty lengths in timer clocks
  assign per_code_len = (per_code == 3'h0) ? 11'h400 : {1'b0, per_code, 7'h00};
  always_comb begin
    if (swap) begin
      period_len = {1'b0, cmpa_reg};
      duty_len = per_code_len;
    end else begin
      period_len = per_code_len;
      duty_len = {1'b0, cmpa_reg};
    end
  end

  assign pwm_active = (duty_len >= period_len) || ({1'b0, cnt_reg} < duty_len);
  assign on_level = ctrl1_reg[C1_OC];
  assign off_level = !ctrl1_reg[C1_OC];
  assign pwm_level = pwm_active ? on_level : off_level;
  assign mode_cmp = (mode == MODE_CMP);
  assign mode_pwm = (mode == MODE_PWM);

  // read data of the addressed register
  always_comb begin
    rd_value = 32'h0000_0000;
    if (sel_cnt_lo) begin
      rd_value = {24'h000000, cnt_reg[7:0]};
    end
    if (sel_cnt_hi) begin
      rd_value = {30'h00000000, cnt_reg[9:8]};
    end
    if (sel_cmpa_lo) begin
      rd_value = {24'h000000, cmpa_reg[7:0]};
    end
    if (sel_cmpa_hi) begin
      rd_value = {30'h00000000, cmpa_reg[9:8]};
    end
    if (sel_ctrl0) begin
      rd_value = {24'h000000, ctrl0_reg};
    end
    if (sel_ctrl1) begin
      rd_value = {24'h000000, ctrl1_reg};
    end
    if (sel_status) begin
      rd_value = {30'h00000000, pf_reg, af_reg};
    end
  end

  // apb slave, one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !known;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= rd_en ? rd_value : 32'h0000_0000;
    end
  end

  // control 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_reg <= CTRL_RST;
    end else if (wr_en && pready && sel_ctrl0) begin
      ctrl0_reg <= pwdata[7:0];
    end
  end

  // control 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_reg <= CTRL_RST;
    end else if (wr_en && pready && sel_ctrl1) begin
      ctrl1_reg <= pwdata[7:0];
    end
  end

  // compare-A low byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpa_reg[7:0] <= CMPA_RST[7:0];
    end else if (wr_en && pready && sel_cmpa_lo) begin
      cmpa_reg[7:0] <= pwdata[7:0];
    end
  end

  // compare-A high bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpa_reg[9:8] <= CMPA_RST[9:8];
    end else if (wr_en && pready && sel_cmpa_hi) begin
      cmpa_reg[9:8] <= pwdata[1:0];
    end
  end

  // counter-on edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_d_reg <= 1'b0;
    end else begin
      on_d_reg <= ctrl0_reg[C0_ON];
    end
  end

  // counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= CNT_RST;
    end else begin
      if (on_rise) begin
        cnt_reg <= CNT_RST;
      end else if (clear_cnt) begin
        cnt_reg <= CNT_RST;
      end else if (running) begin
        cnt_reg <= cnt_inc;
      end
    end
  end

  // flags: write one to clear, set wins
  assign af_clr = wr_en && pready && (paddr == ADDR_STATUS) && pwdata[ST_AF];
  assign pf_clr = wr_en && pready && (paddr == ADDR_STATUS) && pwdata[ST_PF];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      af_reg <= 1'b0;
    end else begin
      af_reg <= set_af || (af_reg && !af_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_reg <= 1'b0;
    end else begin
      pf_reg <= set_pf || (pf_reg && !pf_clr);
    end
  end

  // compare-match pin state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_reg <= 1'b0;
    end else if (on_rise) begin
      pin_reg <= ctrl1_reg[C1_OC];
    end else if (set_af && mode_cmp) begin
      unique case (act)
        ACT_NONE: pin_reg <= pin_reg;
        ACT_LOW: pin_reg <= 1'b0;
        ACT_HIGH: pin_reg <= 1'b1;
        ACT_TOGGLE: pin_reg <= !pin_reg;
      endcase
    end
  end

  // pwm waveform, active level from output-control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_reg <= 1'b0;
    end else begin
      unique case (act)
        2'b00: pwm_reg <= off_level;
        2'b01: pwm_reg <= on_level;
        default: pwm_reg <= pwm_level;
      endcase
    end
  end

  // pin level before the output flop
  always_comb begin
    pin_drive = 1'b0;
    unique case (mode)
      MODE_CMP: pin_drive = pin_reg ^ ctrl1_reg[C1_INV];
      MODE_PWM: pin_drive = pwm_reg ^ ctrl1_reg[C1_INV];
      MODE_CAP: pin_drive = 1'b0;
      MODE_TMR: pin_drive = 1'b0;
    endcase
  end

  // pin drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_out <= 1'b0;
    end else begin
      timer_out <= pin_drive;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_out_en <= 1'b0;
    end else begin
      timer_out_en <= mode_cmp || mode_pwm;
    end
  end

endmodule
`default_nettype wire

// [verif/stm_timer_props.sv]
`timescale 1ns/1ps
`default_nettype none
module stm_timer_props
  import stm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_out,
  input wire logic timer_out_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] c1_reg;
  logic [1:0] age_reg;
  logic on_reg;
  wire logic wr = pready && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_reg <= 8'h00;
      age_reg <= 2'h0;
      on_reg <= 1'b0;
    end else begin
      if (wr && paddr == ADDR_CTRL1) c1_reg <= pwdata[7:0];
      if (wr && paddr == ADDR_CTRL0) on_reg <= pwdata[C0_ON];
      age_reg <= (wr && paddr == ADDR_CTRL1) ? 2'h0 : age_reg + {1'b0, age_reg != 2'h3};
    end
  end
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_hi; pready && !pwrite && (paddr == ADDR_CNT_HI || paddr == ADDR_CMPA_HI)
    |-> prdata[31:2] == 30'h0; endproperty
  a_hi: assert property (p_hi) else $error("high byte upper bits set");
  property p_err; pready && paddr > ADDR_STATUS |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_ok; pready && paddr <= ADDR_STATUS && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mapped refused");
  property p_en; age_reg == 2'h3 |-> timer_out_en == !c1_reg[C1_MODE_LSB]; endproperty
  a_en: assert property (p_en) else $error("pin enable wrong");
  property p_frc; age_reg == 2'h3 && c1_reg[7:5] == 3'b100
    |-> timer_out == ((c1_reg[C1_ACT_LSB] ~^ c1_reg[C1_OC]) ^ c1_reg[C1_INV]); endproperty
  a_frc: assert property (p_frc) else $error("forced level wrong");
  property p_init; wr && paddr == ADDR_CTRL0 && pwdata[C0_ON] && !on_reg && c1_reg[7:6] == 2'b00
    |-> ##3 timer_out == (c1_reg[C1_OC] ^ c1_reg[C1_INV]); endproperty
  a_init: assert property (p_init) else $error("initial level wrong");
  c_init: cover property (wr && paddr == ADDR_CTRL0 && pwdata[C0_ON]);
  c_err: cover property (pready && pslverr);
  c_pwm: cover property (c1_reg[7:6] == 2'b10 && $rose(timer_out));
endmodule
bind stm_timer stm_timer_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_out(timer_out), .timer_out_en(timer_out_en));
`default_nettype wire

// [verif/stm_timer_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module stm_timer_bench
  import stm_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, err, timer_out, timer_out_en;
  int n_errors = 0, n_compared = 0, cyc = 0, h, t;
  stm_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_out(timer_out), .timer_out_en(timer_out_en));
  initial forever #10 pclk = ~pclk;
  task automatic stop_test();
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(logic w, logic [7:0] a, logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(string nm, logic [7:0] a, logic [31:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(nm, exp, q);
  endtask
  task automatic run(logic [7:0] c1, logic [7:0] c0, logic [9:0] ca);
    xfer(1'b1, ADDR_CTRL0, 8'h00);
    xfer(1'b1, ADDR_CMPA_LO, ca[7:0]);
    xfer(1'b1, ADDR_CMPA_HI, {6'h0, ca[9:8]});
    xfer(1'b1, ADDR_CTRL1, c1);
    xfer(1'b1, ADDR_STATUS, 8'h03);
    xfer(1'b1, ADDR_CTRL0, c0);
  endtask
  task automatic wave(logic [7:0] c1, logic [7:0] c0, logic [9:0] ca, int eh, int et);
    run(c1, c0, ca);
    while (timer_out !== 1'b0) @(posedge pclk);
    while (timer_out !== 1'b1) @(posedge pclk);
    for (h = 0; timer_out === 1'b1; h++) @(posedge pclk);
    for (t = h; timer_out !== 1'b1; t++) @(posedge pclk);
    chk("high time", eh, h);
    chk("period", et, t);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) rd("reset value", 8'(4 * i), 32'h0);
    xfer(1'b1, ADDR_CMPA_LO, 8'hA5);
    xfer(1'b1, ADDR_CMPA_HI, 8'hFF);
    xfer(1'b1, ADDR_CNT_LO, 8'h55);
    rd("cmpa low", ADDR_CMPA_LO, 32'hA5);
    rd("cmpa high", ADDR_CMPA_HI, 32'h3);
    rd("counter low", ADDR_CNT_LO, 32'h0);
    rd("unmapped", 8'h1C, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    wave(8'h39, 8'h09, 10'h0C8, 200, 400);
    rd("status", ADDR_STATUS, 32'h1);
    wave(8'h38, 8'h09, 10'h040, 128, 256);
    rd("status", ADDR_STATUS, 32'h3);
    for (int i = 0; i < 3; i++) begin
      run(i == 0 ? 8'h18 : (i == 1 ? 8'h20 : 8'h08), 8'h09, 10'h040);
      repeat (300) @(posedge pclk);
      chk("pin", {31'h0, i == 0 ? 1'b0 : 1'b1}, {31'h0, timer_out});
    end
    run(8'hF8, 8'h09, 10'h040);
    repeat (300) @(posedge pclk);
    chk("pin enable", 32'h0, {31'h0, timer_out_en});
    rd("status", ADDR_STATUS, 32'h3);
    run(8'h40, 8'h08, 10'h3FF);
    xfer(1'b1, ADDR_CTRL0, 8'h88);
    xfer(1'b1, ADDR_CTRL0, 8'h00);
    rd("counter held", ADDR_CNT_LO, 32'h2);
    wave(8'hA9, 8'h0A, 10'h040, 64, 256);
    rd("status", ADDR_STATUS, 32'h3);
    wave(8'hAA, 8'h09, 10'h12C, 128, 300);
    wave(8'hAC, 8'h0A, 10'h040, 192, 256);
    wave(8'hA8, 8'h08, 10'h040, 64, 1024);
    run(8'hA8, 8'h0A, 10'h12C);
    repeat (4) @(posedge pclk);
    h = 0;
    repeat (600) begin
      @(posedge pclk);
      if (timer_out !== 1'b1) h++;
    end
    chk("low cycles", 32'h0, h);
    for (int i = 0; i < 2; i++) begin
      run(8'h88 | 8'(i << 4), 8'h0A, 10'h040);
      repeat (20) @(posedge pclk);
      chk("forced pin", i, {31'h0, timer_out});
    end
    stop_test();
  end
endmodule
`default_nettype wire
